// *** src/dcf_pkg.sv ***
package dcf_pkg;

  // word width and default depth (32K words)
  localparam int DATA_W        = 18;
  localparam int DEPTH_LOG2    = 15;

  // offset defaults picked by the load select level at reset
  localparam logic [15:0] OFF_DEF_SERIAL   = 16'h03FF;
  localparam logic [15:0] OFF_DEF_PARALLEL = 16'h007F;

  // flag pipeline depths, in edges of the flag's own clock
  localparam int EMPTY_STAGES  = 2;
  localparam int READY_STAGES  = 3;
  localparam int FULL_STAGES   = 2;

  // read edges before the first word falls through
  localparam logic [1:0] FT_LATENCY = 2'h3;

  // pin synchroniser depth
  localparam int SYNC_STAGES   = 2;

  typedef enum logic {
    DCF_STANDARD,
    DCF_FALL_THROUGH
  } dcf_mode_t;

endpackage : dcf_pkg

// *** src/dcf_fifo.sv ***
// Functional notes
// - mode pin latched at reset picks timing
// - fall-through shows first word after three edges
// - write on write edge; empty flag rises
// - standard almost-empty high at offset plus one
// - standard half-full low at half plus one
// - standard almost-full low at depth minus offset
// - standard full low at depth; writes blocked
// - standard almost-empty low at offset words
// - empty flag low when drained; reads ignored
// - standard empty/full flags two stages deep
// - fall-through almost-empty high at offset plus two
// - fall-through half-full low at half plus two
// - fall-through almost-full low at depth+1 minus offset
// - input-ready high at depth plus one
// - fall-through drain: output-ready high, reads ignored
// - output-ready three stages, input-ready two stages
// - load select high: serial, offsets 3FF
// - load select low: parallel, offsets 07F
// - offsets read back in both serial and parallel
// - offsets programmable any time after reset
`timescale 1ns/1ns
`default_nettype none

module dcf_fifo #(
  parameter int DEPTH_LOG2 = dcf_pkg::DEPTH_LOG2
) (
  // core clock and reset
  input  wire logic                      CORE_CLK_IN,
  input  wire logic                      SRST_IN,
  // write port
  input  wire logic                      WRITE_CLK_IN,
  input  wire logic                      WRITE_EN_N_IN,
  input  wire logic [dcf_pkg::DATA_W-1:0] DATA_IN,
  // read port
  input  wire logic                      READ_CLK_IN,
  input  wire logic                      READ_EN_N_IN,
  output logic      [dcf_pkg::DATA_W-1:0] DATA_OUT,
  // configuration and offset programming
  input  wire logic                      MODE_SELECT_SERIAL_IN,
  input  wire logic                      LOAD_SELECT_IN,
  input  wire logic                      SERIAL_EN_N_IN,
  // status flags
  output logic                           EMPTY_FLAG_N_OUT,
  output logic                           FULL_FLAG_N_OUT,
  output logic                           ALMOST_EMPTY_FLAG_N_OUT,
  output logic                           ALMOST_FULL_FLAG_N_OUT,
  output logic                           HALF_FULL_FLAG_N_OUT
);

  localparam int DW    = dcf_pkg::DATA_W;
  localparam int L     = DEPTH_LOG2;
  localparam int DEPTH = 1 << L;
  localparam int PW    = 5 + DW;
  localparam int NE    = dcf_pkg::EMPTY_STAGES;
  localparam logic [1:0] FT_M1 = dcf_pkg::FT_LATENCY - 2'h1;

  if (L < 4 || L > 16) begin : g_chk
    $error("dcf_fifo: DEPTH_LOG2 must lie in 4..16");
  end

  // all pins but reset through two flops; clock edges found on the second
  // both pin clocks sit above the PW data and control bits
  logic [PW+1:0] sync1_q;
  logic [PW+1:0] sync2_q;
  logic          wclk_p_q;
  logic          rclk_p_q;

  always_ff @(posedge CORE_CLK_IN) begin
    sync1_q  <= {WRITE_CLK_IN, READ_CLK_IN, WRITE_EN_N_IN, READ_EN_N_IN,
                 LOAD_SELECT_IN, SERIAL_EN_N_IN, MODE_SELECT_SERIAL_IN, DATA_IN};
    sync2_q  <= sync1_q;
    wclk_p_q <= sync2_q[PW+1];
    rclk_p_q <= sync2_q[PW];
  end

  logic          wr_edge;
  logic          rd_edge;
  logic          wen_n;
  logic          ren_n;
  logic          ld;
  logic          sen_n;
  logic          si;
  logic [DW-1:0] din;

  assign wr_edge = sync2_q[PW+1] & ~wclk_p_q;
  assign rd_edge = sync2_q[PW] & ~rclk_p_q;
  assign wen_n   = sync2_q[DW+4];
  assign ren_n   = sync2_q[DW+3];
  assign ld      = sync2_q[DW+2];
  assign sen_n   = sync2_q[DW+1];
  assign si      = sync2_q[DW];
  assign din     = sync2_q[DW-1:0];

  // modes caught while reset is held
  dcf_pkg::dcf_mode_t mode_q;
  logic               serial_q;

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      mode_q   <= si ? dcf_pkg::DCF_FALL_THROUGH : dcf_pkg::DCF_STANDARD;
      serial_q <= ld;
    end
  end

  logic fall_through_mode;
  assign fall_through_mode = (mode_q == dcf_pkg::DCF_FALL_THROUGH);

  // storage and occupancy
  logic [DW-1:0] mem_q [DEPTH];
  logic [L-1:0]  wp_q;
  logic [L-1:0]  rp_q;
  logic [L:0]    cnt_q;
  logic          out_valid_q;
  logic [1:0]    ft_cnt_q;
  logic [L:0]    total;
  logic          mem_full;
  logic          mem_empty;
  logic          wr_mem;
  logic          rd_req;
  logic          rd_pop;
  logic          ft_load;

  assign mem_full  = (cnt_q == (L+1)'(DEPTH));
  assign mem_empty = (cnt_q == '0);
  assign total     = cnt_q + (L+1)'(fall_through_mode & out_valid_q);
  assign wr_mem    = wr_edge & ~wen_n & ld & ~mem_full;
  // reads with nothing stored are dropped
  assign rd_req    = rd_edge & ~ren_n & ld;
  assign ft_load   = fall_through_mode & ~mem_empty &
                     (out_valid_q ? rd_req : (rd_edge & (ft_cnt_q == FT_M1)));
  assign rd_pop    = fall_through_mode ? ft_load : (rd_req & ~mem_empty);

  always_ff @(posedge CORE_CLK_IN) begin
    if (wr_mem) begin
      mem_q[wp_q] <= din;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr_mem) begin
        wp_q <= wp_q + L'(1);
      end
      if (rd_pop) begin
        rp_q <= rp_q + L'(1);
      end
      if (wr_mem && !rd_pop) begin
        cnt_q <= cnt_q + (L+1)'(1);
      end else if (rd_pop && !wr_mem) begin
        cnt_q <= cnt_q - (L+1)'(1);
      end
    end
  end

  // fall-through: count read edges while a word waits
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN || !fall_through_mode || out_valid_q || mem_empty) begin
      ft_cnt_q <= 2'h0;
    end else if (rd_edge) begin
      ft_cnt_q <= ft_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      out_valid_q <= 1'b0;
    end else if (ft_load) begin
      out_valid_q <= 1'b1;
    end else if (fall_through_mode && rd_req && out_valid_q) begin
      out_valid_q <= 1'b0;
    end
  end

  // offset registers
  logic [L-1:0] off_e_q;
  logic [L-1:0] off_f_q;
  logic         pw_sel_q;
  logic         pr_sel_q;
  logic         off_wr;
  logic         off_rd;
  logic         off_sh;

  assign off_wr = wr_edge & ~wen_n & ~ld & ~serial_q;
  assign off_rd = rd_edge & ~ren_n & ~ld;
  assign off_sh = wr_edge & ~sen_n & ~ld & wen_n & serial_q;

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      off_e_q  <= ld ? dcf_pkg::OFF_DEF_SERIAL[L-1:0] : dcf_pkg::OFF_DEF_PARALLEL[L-1:0];
      off_f_q  <= ld ? dcf_pkg::OFF_DEF_SERIAL[L-1:0] : dcf_pkg::OFF_DEF_PARALLEL[L-1:0];
      pw_sel_q <= 1'b0;
    end else if (off_wr) begin
      pw_sel_q <= ~pw_sel_q;
      if (pw_sel_q) begin
        off_f_q <= din[L-1:0];
      end else begin
        off_e_q <= din[L-1:0];
      end
    end else if (off_sh) begin
      // empty lsb enters first, full msb last
      {off_f_q, off_e_q} <= {si, off_f_q, off_e_q[L-1:1]};
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      pr_sel_q <= 1'b0;
      DATA_OUT <= '0;
    end else if (off_rd) begin
      pr_sel_q <= ~pr_sel_q;
      DATA_OUT <= DW'(pr_sel_q ? off_f_q : off_e_q);
    end else if (rd_pop) begin
      DATA_OUT <= mem_q[rp_q];
    end
  end

  // programmable and half flags, thresholds shift by one in fall-through
  logic [L+1:0] fb;
  logic [L+1:0] t_ext;
  logic [L+1:0] ae_thr;
  logic [L+1:0] hf_thr;
  logic [L+1:0] af_thr;

  assign fb     = (L+2)'(fall_through_mode);
  assign t_ext  = (L+2)'(total);
  assign ae_thr = (L+2)'(off_e_q) + (L+2)'(1) + fb;
  assign hf_thr = (L+2)'(DEPTH / 2) + (L+2)'(1) + fb;
  assign af_thr = (L+2)'(DEPTH) - (L+2)'(off_f_q) + fb;

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      ALMOST_EMPTY_FLAG_N_OUT <= 1'b0;
      HALF_FULL_FLAG_N_OUT    <= 1'b1;
      ALMOST_FULL_FLAG_N_OUT  <= 1'b1;
    end else begin
      ALMOST_EMPTY_FLAG_N_OUT <= (t_ext >= ae_thr);
      HALF_FULL_FLAG_N_OUT    <= ~(t_ext >= hf_thr);
      ALMOST_FULL_FLAG_N_OUT  <= ~(t_ext >= af_thr);
    end
  end

  // empty/ready and full/ready stages, advanced on their own edges
  logic [NE-1:0] emp_q;
  logic [dcf_pkg::FULL_STAGES-1:0] ful_q;
  logic emp_raw;
  logic ful_raw;

  // standard empty: high when words stored
  assign emp_raw = (cnt_q != '0);
  assign ful_raw = fall_through_mode ? (mem_full & out_valid_q) : ~mem_full;

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      emp_q <= '0;
    end else if (rd_edge) begin
      emp_q <= {emp_q[NE-2:0], emp_raw};
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      ful_q <= {dcf_pkg::FULL_STAGES{~fall_through_mode}};
    end else if (wr_edge) begin
      ful_q <= {ful_q[dcf_pkg::FULL_STAGES-2:0], ful_raw};
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      // idle level per mode: no word held, room to write
      EMPTY_FLAG_N_OUT <= fall_through_mode;
      FULL_FLAG_N_OUT  <= ~fall_through_mode;
    end else begin
      // fall-through: the three read-edge count is the ready pipeline
      EMPTY_FLAG_N_OUT <= fall_through_mode ? ~out_valid_q
                               : emp_q[dcf_pkg::EMPTY_STAGES-1];
      FULL_FLAG_N_OUT  <= ful_q[dcf_pkg::FULL_STAGES-1];
    end
  end

  // checks
  sequence s_wait_first;
    fall_through_mode && !out_valid_q && !mem_empty && ft_cnt_q == FT_M1 && rd_edge;
  endsequence

  property p_first_fall;
    @(posedge CORE_CLK_IN) disable iff (SRST_IN)
      s_wait_first |=> out_valid_q;
  endproperty
  a_first_fall: assert property (p_first_fall) else $error("first word missed");

  property p_no_early_fall;
    @(posedge CORE_CLK_IN) disable iff (SRST_IN)
      $rose(out_valid_q) |-> $past(ft_cnt_q) == FT_M1;
  endproperty
  a_no_early_fall: assert property (p_no_early_fall) else $error("early fall");

  property p_write_counts;
    @(posedge CORE_CLK_IN) disable iff (SRST_IN)
      wr_mem && !rd_pop |=> cnt_q == $past(cnt_q) + (L+1)'(1);
  endproperty
  a_write_counts: assert property (p_write_counts) else $error("write lost");

  property p_full_blocks;
    @(posedge CORE_CLK_IN) disable iff (SRST_IN)
      mem_full && !rd_pop |=> cnt_q == (L+1)'(DEPTH);
  endproperty
  a_full_blocks: assert property (p_full_blocks) else $error("write past full");

  property p_empty_ignores;
    @(posedge CORE_CLK_IN) disable iff (SRST_IN)
      !fall_through_mode && mem_empty && rd_req |=> $stable(DATA_OUT) && cnt_q == (L+1)'($past(wr_mem));
  endproperty
  a_empty_ignores: assert property (p_empty_ignores) else $error("read on empty");

  property p_ae_flag;
    @(posedge CORE_CLK_IN) disable iff (SRST_IN)
      !fall_through_mode |=> ALMOST_EMPTY_FLAG_N_OUT == ($past(cnt_q) > {1'b0, $past(off_e_q)});
  endproperty
  a_ae_flag: assert property (p_ae_flag) else $error("almost-empty wrong");

  property p_hf_flag;
    @(posedge CORE_CLK_IN) disable iff (SRST_IN)
      !fall_through_mode |=> HALF_FULL_FLAG_N_OUT == ($past(cnt_q) <= (L+1)'(DEPTH / 2));
  endproperty
  a_hf_flag: assert property (p_hf_flag) else $error("half-full wrong");

  property p_af_flag;
    @(posedge CORE_CLK_IN) disable iff (SRST_IN)
      !fall_through_mode |=> ALMOST_FULL_FLAG_N_OUT ==
        ((L+2)'($past(cnt_q)) + (L+2)'($past(off_f_q)) < (L+2)'(DEPTH));
  endproperty
  a_af_flag: assert property (p_af_flag) else $error("almost-full wrong");

  property p_empty_holds;
    @(posedge CORE_CLK_IN) disable iff (SRST_IN)
      !rd_edge ##1 !rd_edge |=> $stable(EMPTY_FLAG_N_OUT);
  endproperty
  a_empty_holds: assert property (p_empty_holds) else $error("flag moved");

  property p_drain_ignored;
    @(posedge CORE_CLK_IN) disable iff (SRST_IN)
      fall_through_mode && !out_valid_q && mem_empty |=> !$rose(out_valid_q) || !$past(mem_empty);
  endproperty
  a_drain_ignored: assert property (p_drain_ignored) else $error("ready on drain");

endmodule : dcf_fifo

`default_nettype wire

// *** dv/dcf_peer.sv ***
`timescale 1ns/1ns
`default_nettype none

module dcf_peer (
  // core clock
  input  wire logic                       clk_in,
  // pin side of the buffer
  output var logic                        wclk_out,
  output var logic                        rclk_out,
  output var logic                        wen_n_out,
  output var logic                        ren_n_out,
  output var logic [dcf_pkg::DATA_W-1:0]  din_out
);

  initial begin
    wclk_out  = 1'b0;
    rclk_out  = 1'b0;
    wen_n_out = 1'b1;
    ren_n_out = 1'b1;
    din_out   = '0;
  end

  // one pin clock pulse; clocks stand still between pulses
  task automatic pulse(input logic rd, input logic en_n, input logic [17:0] d);
    @(posedge clk_in);
    if (rd) ren_n_out <= en_n;
    else begin
      wen_n_out <= en_n;
      din_out   <= d;
    end
    // enables held 4 core cycles each side of the pulse, since the pins pass a synchroniser
    repeat (4) @(posedge clk_in);
    if (rd) rclk_out <= 1'b1;
    else wclk_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    rclk_out <= 1'b0;
    wclk_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    ren_n_out <= 1'b1;
    wen_n_out <= 1'b1;
    // released data lines show no stale word
    din_out   <= ~din_out;
  endtask : pulse

endmodule : dcf_peer
`default_nettype wire

// *** dv/dual_clock_fifo_flag_modes_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module dual_clock_fifo_flag_modes_tb;
  // small depth keeps fill and drain short
  localparam int LOG2 = 4;
  localparam int D    = 16;

  logic        clk, srst, mode, ld, sen_n, ft;
  wire         wclk, rclk, wen_n, ren_n, ef_n, ff_n, ae_n, af_n, hf_n;
  wire  [17:0] din, dout;
  logic [17:0] w;
  logic [17:0] q[$];
  logic [15:0] e;
  int          mismatches, n_checks, cycles, cnt, n, m, fv;

  dcf_fifo #(.DEPTH_LOG2(LOG2)) dcf_fifo_i (
    .CORE_CLK_IN(clk), .SRST_IN(srst), .WRITE_CLK_IN(wclk), .WRITE_EN_N_IN(wen_n),
    .DATA_IN(din), .READ_CLK_IN(rclk), .READ_EN_N_IN(ren_n), .DATA_OUT(dout),
    .MODE_SELECT_SERIAL_IN(mode), .LOAD_SELECT_IN(ld), .SERIAL_EN_N_IN(sen_n),
    .EMPTY_FLAG_N_OUT(ef_n), .FULL_FLAG_N_OUT(ff_n), .ALMOST_EMPTY_FLAG_N_OUT(ae_n),
    .ALMOST_FULL_FLAG_N_OUT(af_n), .HALF_FULL_FLAG_N_OUT(hf_n));

  dcf_peer dcf_peer_i (
    .clk_in(clk), .wclk_out(wclk), .rclk_out(rclk), .wen_n_out(wen_n),
    .ren_n_out(ren_n), .din_out(din));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rb(input logic [17:0] exp);
    dcf_peer_i.pulse(1'b1, 1'b0, '0);
    check(dout, exp);
  endtask : rb

  // idle pin edges let the staged flags catch up
  task automatic flags();
    repeat (3) begin
      dcf_peer_i.pulse(1'b0, 1'b1, '0);
      dcf_peer_i.pulse(1'b1, 1'b1, '0);
    end
    repeat (2) @(posedge clk);
    check(ef_n, ft ? (cnt == 0) : (cnt != 0));
    if (ft) check(ff_n, cnt > D);
    else check(ff_n, cnt < D);
    check(ae_n, cnt > n + fv);
    check(af_n, cnt < D + fv - m);
    check(hf_n, cnt < D / 2 + 1 + fv);
    if (ft && cnt > 0) check(dout, q[0]);
  endtask : flags

  task automatic run(input logic f, input logic l);
    @(posedge clk);
    srst <= 1'b1;
    mode <= f;
    ld   <= l;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    ld   <= 1'b0;
    ft = f;
    fv = f;
    cnt = 0;
    q.delete();
    e = l ? dcf_pkg::OFF_DEF_SERIAL : dcf_pkg::OFF_DEF_PARALLEL;
    rb(18'(e[LOG2-1:0]));
    rb(18'(e[LOG2-1:0]));
    // idle flags straight after reset, after only the two offset read-back pulses
    check(ef_n, f);
    check(ff_n, !f);
    n = 1 + $urandom % 4;
    m = 1 + $urandom % 4;
    dcf_peer_i.pulse(1'b0, 1'b0, 18'(n));
    dcf_peer_i.pulse(1'b0, 1'b0, 18'(m));
    // serial loading refuses the parallel writes, then takes the same values bit by bit
    if (l) begin
      rb(18'(e[LOG2-1:0]));
      rb(18'(e[LOG2-1:0]));
      sen_n <= 1'b0;
      for (int k = 0; k < 2 * LOG2; k++) begin
        mode <= (k < LOG2) ? n[k] : m[k - LOG2];
        dcf_peer_i.pulse(1'b0, 1'b1, '0);
      end
      sen_n <= 1'b1;
    end
    rb(18'(n));
    rb(18'(m));
    @(posedge clk);
    ld <= 1'b1;
    flags();
    repeat (D + 2) begin
      w = $urandom;
      dcf_peer_i.pulse(1'b0, 1'b0, w);
      if (cnt < D + fv) begin
        cnt++;
        q.push_back(w);
      end
      flags();
    end
    repeat (D + 2) begin
      dcf_peer_i.pulse(1'b1, 1'b0, '0);
      if (cnt > 0) begin
        if (!ft) check(dout, q[0]);
        void'(q.pop_front());
        cnt--;
      end
      flags();
    end
    $display("test mode %0d load %0d done", f, l);
  endtask : run

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    srst = 1'b1;
    mode = 1'b0;
    ld = 1'b0;
    sen_n = 1'b1;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    void'($urandom(43324));
    for (int i = 0; i < 4; i++) begin
      run(i[0], i[1]);
    end
    results();
  end

endmodule : dual_clock_fifo_flag_modes_tb
`default_nettype wire
